// ### logic/amss_cfg.svh
`ifndef AMSS_CFG_SVH
`define AMSS_CFG_SVH

// number of chip-select spaces, each with its own timing set
`define AMSS_SPACES 4
`define AMSS_SPACE_W 2
// programmed count field widths
`define AMSS_SETUP_W 4
`define AMSS_STROBE_W 6
`define AMSS_HOLD_W 3
// common down-counter width, wide enough for the strobe field
`define AMSS_CNT_W 6
// external bus widths
`define AMSS_ADDR_HI 21
`define AMSS_ADDR_LO 2
`define AMSS_DATA_W 32
`define AMSS_BE_W 4
// timing set loaded into every space at reset
`define AMSS_RST_SETUP 4'hf
`define AMSS_RST_STROBE 6'h3f
`define AMSS_RST_HOLD 3'h3
// counter constants
`define AMSS_CNT_ONE 6'h01
`define AMSS_CNT_ZERO 6'h00
// idle level of the wait-release synchroniser
`define AMSS_RDY_IDLE 3'h7

`endif

// ### logic/amss_pkg.sv
`include "amss_cfg.svh"

package amss_pkg;

  // one timing set per chip-select space
  typedef struct packed {
    logic [`AMSS_SETUP_W-1:0] rd_setup;
    logic [`AMSS_STROBE_W-1:0] rd_strobe;
    logic [`AMSS_HOLD_W-1:0] rd_hold;
    logic [`AMSS_SETUP_W-1:0] wr_setup;
    logic [`AMSS_STROBE_W-1:0] wr_strobe;
    logic [`AMSS_HOLD_W-1:0] wr_hold;
  } amss_timing_t;

  // one access request from the controller core
  typedef struct packed {
    logic write;
    logic [`AMSS_SPACE_W-1:0] space;
    logic [`AMSS_ADDR_HI:`AMSS_ADDR_LO] addr;
    logic [`AMSS_BE_W-1:0] byte_en;
    logic [`AMSS_DATA_W-1:0] wdata;
  } amss_req_t;

  typedef enum logic [2:0] {
    AMSS_IDLE = 3'b000,
    AMSS_LOAD = 3'b001,
    AMSS_SETUP = 3'b010,
    AMSS_STROBE = 3'b011,
    AMSS_EXTEND = 3'b100,
    AMSS_HOLD = 3'b101
  } amss_state_t;

endpackage : amss_pkg

// ### logic/amss_timing_mem.sv
`timescale 1ns/10ps
`include "amss_cfg.svh"

module amss_timing_mem (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire logic [`AMSS_SPACE_W-1:0] cfg_space,
  input wire amss_pkg::amss_timing_t cfg_timing,
  input wire logic [`AMSS_SPACE_W-1:0] rd_space,
  output amss_pkg::amss_timing_t rd_timing
);

  localparam amss_pkg::amss_timing_t RST_SET = '{rd_setup: `AMSS_RST_SETUP, rd_strobe: `AMSS_RST_STROBE,
    rd_hold: `AMSS_RST_HOLD, wr_setup: `AMSS_RST_SETUP, wr_strobe: `AMSS_RST_STROBE, wr_hold: `AMSS_RST_HOLD};

  amss_pkg::amss_timing_t mem_q [`AMSS_SPACES];
  amss_pkg::amss_timing_t mem_d [`AMSS_SPACES];
  amss_pkg::amss_timing_t rd_d;

  // per-space write port; longest setup and strobe after reset, hold at 3 of a possible 7
  always_comb begin
    for (int i = 0; i < `AMSS_SPACES; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (cfg_we) begin
      mem_d[cfg_space] = cfg_timing;
    end
    rd_d = mem_q[rd_space];
  end

  // read data leave through a register, one cycle after the address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `AMSS_SPACES; i++) begin
        mem_q[i] <= RST_SET;
      end
      rd_timing <= RST_SET;
    end else begin
      for (int i = 0; i < `AMSS_SPACES; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rd_timing <= rd_d;
    end
  end

endmodule : amss_timing_mem

// ### logic/amss_sequencer.sv
//Contract
//- read selects valid setup cycles before strobe
//- read strobe low exactly strobe count cycles
//- read selects held hold cycles after strobe
//- write selects and data valid setup cycles
//- write strobe low exactly strobe count cycles
//- write selects and data held hold cycles
//- wait-release input synchronised, one cycle slack
//- read strobe rises 3 to 4 cycles after release
//- write strobe rises 3 to 4 cycles after release
//- selects: chip select, lanes, address, enable, data
//- chip select may linger after hold ends
//- six counts kept per chip-select space
`timescale 1ns/10ps
`include "amss_cfg.svh"

module amss_sequencer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire logic [`AMSS_SPACE_W-1:0] cfg_space,
  input wire amss_pkg::amss_timing_t cfg_timing,
  input wire logic req_valid,
  input wire amss_pkg::amss_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`AMSS_DATA_W-1:0] rsp_rdata,
  output logic [`AMSS_SPACES-1:0] chip_select_n,
  output logic [`AMSS_BE_W-1:0] byte_lane_enable_n,
  output logic [`AMSS_ADDR_HI:`AMSS_ADDR_LO] ext_addr,
  output logic output_enable_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [`AMSS_DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [`AMSS_DATA_W-1:0] ext_data_in,
  input wire logic strobe_extend_in
);

  // a zero count still gives one cycle of the phase
  function automatic logic [`AMSS_CNT_W-1:0] amss_min1(input logic [`AMSS_CNT_W-1:0] v);
    amss_min1 = (v == `AMSS_CNT_ZERO) ? `AMSS_CNT_ONE : v;
  endfunction : amss_min1

  amss_pkg::amss_state_t state_q, state_d;
  amss_pkg::amss_req_t op_q, op_d;
  amss_pkg::amss_timing_t tim;
  logic [`AMSS_CNT_W-1:0] cnt_q, cnt_d;
  logic [`AMSS_DATA_W-1:0] rdata_d;
  logic rsp_d;
  logic [2:0] sync_q, sync_d;
  logic rdy_hold_q, rdy_hold_d;
  logic rdy_eff;
  logic [`AMSS_CNT_W-1:0] hold_cnt;
  logic [`AMSS_SPACES-1:0] cs_d;
  logic [`AMSS_BE_W-1:0] be_d;
  logic [`AMSS_ADDR_HI:`AMSS_ADDR_LO] addr_d;
  logic oe_n_d, rd_n_d, wr_n_d, data_oe_d, ready_d;
  logic [`AMSS_DATA_W-1:0] wdata_d;
  logic active_d;
  logic [`AMSS_SPACE_W-1:0] tim_space;

  // timing set follows the running op; req may move once it has been taken
  always_comb begin
    tim_space = (state_q == amss_pkg::AMSS_IDLE) ? req.space : op_q.space;
  end

  amss_timing_mem u_timing_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cfg_we(cfg_we),
    .cfg_space(cfg_space),
    .cfg_timing(cfg_timing),
    .rd_space(tim_space),
    .rd_timing(tim)
  );

  // three-stage synchroniser; the level counts once stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], strobe_extend_in};
    rdy_eff = (sync_q[1] == sync_q[2]) ? sync_q[2] : rdy_hold_q;
    rdy_hold_d = rdy_eff;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= `AMSS_RDY_IDLE;
      rdy_hold_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      rdy_hold_q <= rdy_hold_d;
    end
  end

  // hold count of the running op, zero skips the hold phase
  always_comb begin
    if (op_q.write) begin
      hold_cnt = {{(`AMSS_CNT_W-`AMSS_HOLD_W){1'b0}}, tim.wr_hold};
    end else begin
      hold_cnt = {{(`AMSS_CNT_W-`AMSS_HOLD_W){1'b0}}, tim.rd_hold};
    end
  end

  // phase sequencer; the timing set stays on the memory output during the op
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    op_d = op_q;
    rdata_d = rsp_rdata;
    rsp_d = 1'b0;
    case (state_q)
      amss_pkg::AMSS_IDLE: begin
        if (req_valid) begin
          op_d = req;
          state_d = amss_pkg::AMSS_LOAD;
        end
      end
      amss_pkg::AMSS_LOAD: begin
        state_d = amss_pkg::AMSS_SETUP;
        if (op_q.write) begin
          cnt_d = amss_min1({{(`AMSS_CNT_W-`AMSS_SETUP_W){1'b0}}, tim.wr_setup});
        end else begin
          cnt_d = amss_min1({{(`AMSS_CNT_W-`AMSS_SETUP_W){1'b0}}, tim.rd_setup});
        end
      end
      amss_pkg::AMSS_SETUP: begin
        if (cnt_q == `AMSS_CNT_ONE) begin
          state_d = amss_pkg::AMSS_STROBE;
          cnt_d = amss_min1(op_q.write ? tim.wr_strobe : tim.rd_strobe);
        end else begin
          cnt_d = cnt_q - `AMSS_CNT_ONE;
        end
      end
      amss_pkg::AMSS_STROBE, amss_pkg::AMSS_EXTEND: begin
        if (state_q == amss_pkg::AMSS_STROBE && cnt_q != `AMSS_CNT_ONE) begin
          cnt_d = cnt_q - `AMSS_CNT_ONE;
        end else if (!rdy_eff) begin
          // low at the last strobe cycle stretches it; relies on partner timing
          state_d = amss_pkg::AMSS_EXTEND;
        end else begin
          // release seen: strobe rises at this edge, 3 to 4 cycles after the pin
          rsp_d = 1'b1;
          if (!op_q.write) begin
            rdata_d = ext_data_in;
          end
          cnt_d = hold_cnt;
          state_d = (hold_cnt == `AMSS_CNT_ZERO) ? amss_pkg::AMSS_IDLE : amss_pkg::AMSS_HOLD;
        end
      end
      amss_pkg::AMSS_HOLD: begin
        if (cnt_q == `AMSS_CNT_ONE) begin
          state_d = amss_pkg::AMSS_IDLE;
        end else begin
          cnt_d = cnt_q - `AMSS_CNT_ONE;
        end
      end
      default: begin
        state_d = amss_pkg::AMSS_IDLE;
      end
    endcase
  end

  // pin levels from the next state, so every output leaves a flip-flop
  always_comb begin
    active_d = (state_d == amss_pkg::AMSS_SETUP) || (state_d == amss_pkg::AMSS_STROBE) ||
      (state_d == amss_pkg::AMSS_EXTEND) || (state_d == amss_pkg::AMSS_HOLD);
    cs_d = {`AMSS_SPACES{1'b1}};
    if (active_d) begin
      cs_d[op_d.space] = 1'b0;
    end
    // address keeps its last value when idle; chip select, lanes and enables release
    addr_d = op_d.addr;
    be_d = active_d ? ~op_d.byte_en : {`AMSS_BE_W{1'b1}};
    oe_n_d = !(active_d && !op_d.write);
    rd_n_d = !(!op_d.write && ((state_d == amss_pkg::AMSS_STROBE) || (state_d == amss_pkg::AMSS_EXTEND)));
    wr_n_d = !(op_d.write && ((state_d == amss_pkg::AMSS_STROBE) || (state_d == amss_pkg::AMSS_EXTEND)));
    data_oe_d = active_d && op_d.write;
    wdata_d = op_d.wdata;
    ready_d = (state_d == amss_pkg::AMSS_IDLE);
  end

  // chip select rises with the hold end, well inside the allowed linger
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= amss_pkg::AMSS_IDLE;
      cnt_q <= `AMSS_CNT_ZERO;
      op_q <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      req_ready <= 1'b1;
      chip_select_n <= {`AMSS_SPACES{1'b1}};
      byte_lane_enable_n <= {`AMSS_BE_W{1'b1}};
      ext_addr <= '0;
      output_enable_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      ext_data_out <= '0;
      ext_data_oe <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      rsp_valid <= rsp_d;
      rsp_rdata <= rdata_d;
      req_ready <= ready_d;
      chip_select_n <= cs_d;
      byte_lane_enable_n <= be_d;
      ext_addr <= addr_d;
      output_enable_n <= oe_n_d;
      read_strobe_n <= rd_n_d;
      write_strobe_n <= wr_n_d;
      ext_data_out <= wdata_d;
      ext_data_oe <= data_oe_d;
    end
  end

endmodule : amss_sequencer

// ### verif/amss_seq_props.sv
`timescale 1ns/10ps
// pin protocol checks of the strobe sequencer
module amss_seq_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic [3:0] chip_select_n,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic [21:2] ext_addr,
  input wire logic output_enable_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic ext_data_oe,
  input wire logic [31:0] ext_data_in,
  input wire logic strobe_extend_in
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_read_setup: assert property ($fell(read_strobe_n) |-> $past(!output_enable_n && chip_select_n != 4'hf))
    else $error("read strobe without setup");
  a_write_setup: assert property ($fell(write_strobe_n) |-> $past(ext_data_oe && chip_select_n != 4'hf))
    else $error("write strobe without setup");
  a_read_bus_free: assert property (!read_strobe_n |-> !ext_data_oe && write_strobe_n)
    else $error("bus driven in read");
  a_idle_release: assert property (req_ready |-> &chip_select_n && &byte_lane_enable_n
    && output_enable_n && !ext_data_oe) else $error("selects active while idle");
  a_sel_steady: assert property (!(read_strobe_n && write_strobe_n) && !$past(read_strobe_n && write_strobe_n)
    |-> $stable(ext_addr) && $stable(byte_lane_enable_n)) else $error("selects moved in strobe");
  a_read_capture: assert property ($rose(read_strobe_n) |-> rsp_valid && rsp_rdata == $past(ext_data_in))
    else $error("read data not captured");
  // pin is moved off the clock edge, so only the three flop path applies
  a_read_release: assert property ($rose(strobe_extend_in) && !read_strobe_n
    |-> ##2 !read_strobe_n ##[1:2] read_strobe_n) else $error("read strobe release late");
  a_write_release: assert property ($rose(strobe_extend_in) && !write_strobe_n
    |-> ##2 !write_strobe_n ##[1:2] write_strobe_n) else $error("write strobe release late");
  c_read_ext: cover property ($rose(strobe_extend_in) && !read_strobe_n);
  c_write_ext: cover property ($rose(strobe_extend_in) && !write_strobe_n);
  c_read_done: cover property ($rose(read_strobe_n) ##1 req_ready);
endmodule : amss_seq_props

bind amss_sequencer amss_seq_props u_amss_seq_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n),
  .byte_lane_enable_n(byte_lane_enable_n), .ext_addr(ext_addr), .output_enable_n(output_enable_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ext_data_oe(ext_data_oe),
  .ext_data_in(ext_data_in), .strobe_extend_in(strobe_extend_in));

// ### verif/amss_mem_model.sv
`timescale 1ns/10ps
// async sram with a ready line that can stretch strobes
module amss_mem_model (
  input wire logic clk_sys,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic [21:2] ext_addr,
  input wire logic output_enable_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [31:0] ext_data_out,
  input wire logic [7:0] wait_len,
  output logic [31:0] ext_data_in = 32'h0,
  output logic strobe_extend_in = 1'b1
);
  logic [31:0] mem [16] = '{default: 32'h0};
  int cnt = 0;
  // lanes land while the write strobe is low
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (!write_strobe_n && !byte_lane_enable_n[i]) mem[ext_addr[5:2]][8 * i +: 8] <= ext_data_out[8 * i +: 8];
    end
  end
  // released bus toggles so a stale word never passes for data
  always @(negedge clk_sys) begin
    ext_data_in <= output_enable_n ? ~ext_data_in : mem[ext_addr[5:2]];
    cnt = (read_strobe_n && write_strobe_n) ? 0 : cnt + 1;
    strobe_extend_in <= cnt == 0 || cnt > wait_len;
  end
endmodule : amss_mem_model

// ### verif/amss_sequencer_test.sv
`timescale 1ns/10ps
module amss_sequencer_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_we = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] cfg_space = 2'h0;
  logic [7:0] wait_len = 8'h00;
  amss_pkg::amss_timing_t cfg_timing = '0;
  amss_pkg::amss_req_t req = '0;
  logic req_ready, rsp_valid, output_enable_n, read_strobe_n, write_strobe_n, ext_data_oe, strobe_extend_in;
  logic [31:0] rsp_rdata, ext_data_out, ext_data_in;
  logic [3:0] chip_select_n, byte_lane_enable_n;
  logic [21:2] ext_addr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int tset [4][6];
  logic [31:0] mref [16] = '{default: 32'h0};

  amss_sequencer u_amss_sequencer (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_we(cfg_we), .cfg_space(cfg_space),
    .cfg_timing(cfg_timing), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n), .byte_lane_enable_n(byte_lane_enable_n),
    .ext_addr(ext_addr), .output_enable_n(output_enable_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_data_in(ext_data_in), .strobe_extend_in(strobe_extend_in));
  amss_mem_model u_mem (.clk_sys(clk_sys), .byte_lane_enable_n(byte_lane_enable_n), .ext_addr(ext_addr),
    .output_enable_n(output_enable_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_data_out(ext_data_out), .wait_len(wait_len), .ext_data_in(ext_data_in),
    .strobe_extend_in(strobe_extend_in));

  initial forever #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // random set; strobe of four or more keeps stretching legal
  task automatic cfg(input int s);
    for (int k = 0; k < 6; k++) tset[s][k] = (k % 3 == 1) ? 4 + $urandom % 4 : $urandom % 4;
    cfg_space = 2'(s);
    cfg_timing = {4'(tset[s][0]), 6'(tset[s][1]), 3'(tset[s][2]), 4'(tset[s][3]), 6'(tset[s][4]), 3'(tset[s][5])};
    cfg_we = 1'b1;
    @(negedge clk_sys);
  endtask : cfg

  // one access, phase lengths measured on the pins
  task automatic op(input logic w, input int s, input logic x);
    logic [19:0] a;
    logic [31:0] d;
    logic [3:0] be;
    int b, pre, stb, hld, wl, nrsp;
    a = 20'($urandom);
    d = $urandom;
    be = 4'($urandom);
    b = w ? 3 : 0;
    pre = 0;
    stb = 0;
    hld = 0;
    nrsp = 0;
    wl = x ? tset[s][b + 1] + 1 + $urandom % 3 : 0;
    wait_len = 8'(wl);
    req = {w, 2'(s), a, be, d};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    // request only needs to stand in the take cycle; scramble it afterwards
    req = 59'({$urandom, $urandom});
    repeat (300) begin
      @(negedge clk_sys);
      if (!(w ? write_strobe_n : read_strobe_n)) begin
        stb++;
        if (stb == 1) chk({chip_select_n, byte_lane_enable_n, output_enable_n, ext_data_oe}, {~(4'h1 << s), ~be, w, w});
        if (stb == 1) chk(w ? ext_data_out : ext_addr, w ? d : a);
      end else if (!chip_select_n[s]) begin
        if (stb == 0) pre++;
        else hld++;
      end
      if (rsp_valid && !w) chk(rsp_rdata, mref[a[3:0]]);
      if (rsp_valid) nrsp++;
      if (stb > 0 && req_ready) break;
    end
    chk(pre, tset[s][b] > 0 ? tset[s][b] : 1);
    // a stretched strobe may end in either of two slots
    chk(x ? (stb - wl + 5) / 2 : stb, x ? 4 : tset[s][b + 1]);
    chk(hld, tset[s][b + 2]);
    chk(nrsp, 1);
    for (int i = 0; i < 4; i++) begin
      if (w && be[i]) mref[a[3:0]][8 * i +: 8] = d[8 * i +: 8];
    end
  endtask : op

  // reset set first, then per-space sets with random traffic
  initial begin
    void'($urandom(82));
    for (int k = 0; k < 4; k++) tset[k] = '{15, 63, 3, 15, 63, 3};
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({req_ready, chip_select_n, ext_data_oe, read_strobe_n, write_strobe_n}, 8'hfb);
    op(1'b0, 0, 1'b0);
    op(1'b1, 3, 1'b1);
    for (int k = 0; k < 4; k++) cfg(k);
    cfg_we = 1'b0;
    repeat (48) op(1'($urandom), $urandom % 4, $urandom % 3 == 0);
    stop_test();
  end

  // about 800 cycles expected; generous cut-off
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
endmodule : amss_sequencer_test
